// ---- src/spip_port.v ----
// Serial slave register port: frame decode, burst addressing, reset register,
// status/mask/summary registers and interrupt output.
// Assumes serial pins are asynchronous and far slower than core_clk_i (>= 4 samples per phase).
`timescale 1ns/1ps
`include "spip_defines.vh"

// Summary of operation
// [R1] Serial port enabled only for select 10.
// [R2] Device is slave; master drives clock, select.
// [R3] Sample edge set by phase, polarity straps.
// [R4] All bytes shifted most significant first.
// [R5] First byte: direction, six zeros, A7.
// [R6] Second byte: A6..A0 then burst flag.
// [R7] Burst read advances, next bit next edge.
// [R8] Burst write advances after each byte.
// [R9] Select release ends any access.
// [R10] Partial write byte is never stored.
// [R11] Burst read prefetch triggers read side effects.
// [R12] Write data stored at address, then upward.
// [R13] Read data sent from address, then upward.
// [R14] Address wraps from top to zero.
// [R15] Power-up clears all writable registers.
// [R16] Hardware reset pin resets registers anytime.
// [R17] Soft reset bit clears, self-clears after.
// [R18] Line reset bit pulses line circuitry reset.
// [R19] Bits 4,5 force outputs to known states.
// [R20] Host writes zero to unused reset bits.
// [R21] Masked status bits alone raise interrupt.
// [R22] Host clears masks while servicing interrupts.
// [R23] Summary bits 0..4 flag active status registers.
// [R24] Data output released while select is high.
module spip_port #(
	parameter NSTAT       = 5,
	parameter LI_RST_CYC  = `SPIP_LI_RECOVER_US * `SPIP_CLK_MHZ
) (
	// Clock and reset.
	input  wire                 core_clk_i,
	input  wire                 reset_n_i,
	// Straps and reset pin.
	input  wire [1:0]           bus_interface_select_i,
	input  wire                 cpha_i,
	input  wire                 cpol_i,
	input  wire                 hardware_reset_pin_n_i,
	// Serial link.
	input  wire                 sck_i,
	input  wire                 mosi_i,
	input  wire                 cs_n_i,
	output reg                  miso_o,
	output reg                  miso_oe_o,
	// Block side.
	input  wire [8*NSTAT-1:0]   status_event_i,
	output reg                  irq_n_o,
	output reg                  line_interface_reset_o,
	output reg                  output_force_mode_low_o,
	output reg                  output_force_mode_high_o
);

	// ----------------------------------------------------------------
	// Reset release and input synchronisation
	// ----------------------------------------------------------------
	reg        rst_s1_q;
	reg        rst_n_q;
	wire [7:0] pins_s;

	// Reset asserts at once, releases after two clocks.
	always @(posedge core_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	spip_sync2 #(
		.W (8)
	) u_sync (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_q),
		.async_i    ({bus_interface_select_i, cpha_i, cpol_i, hardware_reset_pin_n_i,
		              sck_i, mosi_i, ~cs_n_i}),
		.sync_o     (pins_s)
	);

	wire [1:0] sel_s   = pins_s[7:6];
	wire       cpha_s  = pins_s[5];
	wire       cpol_s  = pins_s[4];
	wire       hwrst_s = ~pins_s[3];
	wire       sck_s   = pins_s[2];
	wire       mosi_s  = pins_s[1];
	wire       cs_s    = pins_s[0];

	// ----------------------------------------------------------------
	// Serial edge detection
	// ----------------------------------------------------------------
	reg  sck_q;
	// [R1] serial select check
	wire port_en  = (sel_s == `SPIP_SEL_SERIAL) && cs_s;
	wire rise     = sck_s & ~sck_q;
	wire fall     = ~sck_s & sck_q;
	// [R3] mode 0/3 sample on rising, 1/2 on falling
	wire lead     = cpol_s ? fall : rise;
	wire trail    = cpol_s ? rise : fall;
	wire samp_e   = port_en && (cpha_s ? trail : lead);
	wire shift_e  = port_en && (cpha_s ? lead : trail);

	// ----------------------------------------------------------------
	// Frame state
	// ----------------------------------------------------------------
	localparam ST_CTL0 = 3'b001;
	localparam ST_CTL1 = 3'b010;
	localparam ST_DATA = 3'b100;

	reg [2:0] st_q;
	reg [2:0] bit_q;
	reg [7:0] sh_q;
	reg       rd_q;
	reg       burst_q;
	reg [7:0] addr_q;
	reg [7:0] tx_q;
	reg       sent_q;

	wire [7:0] rx_byte = {sh_q[6:0], mosi_s};
	wire       byte_end = samp_e && (bit_q == `SPIP_BYTE_LAST);

	// ----------------------------------------------------------------
	// Register space
	// ----------------------------------------------------------------
	reg  [7:0] rst_reg_q;
	reg  [7:0] line_rst_q;
	reg        soft_clr_q;
	reg  [7:0] rdata;
	wire [NSTAT-1:0] active;
	wire [7:0] stat_v;
	wire [7:0] mask_v;

	// Registers clear on any of the three reset sources.
	// [R15] power-up clear
	// [R16] reset pin clears
	wire reg_clear = hwrst_s | soft_clr_q;

	// [R10] [R12] whole-byte write strobe
	wire wr_strobe = (st_q == ST_DATA) && byte_end && !rd_q;
	// [R11] prefetch fetch strobe
	wire rd_fetch  = rd_q && byte_end && (st_q == ST_CTL1 || (st_q == ST_DATA && burst_q));
	wire [7:0] fetch_addr = (st_q == ST_CTL1) ? {addr_q[7], rx_byte[7:1]} : addr_inc(addr_q);

	// [R14] wrapping increment
	function [7:0] addr_inc;
		input [7:0] a;
		begin
			addr_inc = a + 8'h01;
		end
	endfunction

	function in_bank;
		input [7:0] a;
		input [7:0] base;
		begin
			in_bank = (a >= base) && (a < base + NSTAT[7:0]);
		end
	endfunction

	wire [7:0] bank_addr = wr_strobe ? addr_q : fetch_addr;
	wire [7:0] stat_off = bank_addr - `SPIP_ADDR_STAT_BASE;
	wire [7:0] mask_off = bank_addr - `SPIP_ADDR_MASK_BASE;
	wire [2:0] bank_idx = in_bank(bank_addr, `SPIP_ADDR_STAT_BASE) ? stat_off[2:0]
	                      : mask_off[2:0];

	spip_stat_bank #(
		.NREG (NSTAT)
	) u_bank (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_q),
		.clear_i    (reg_clear),
		.idx_i      (bank_idx),
		.stat_rd_i  (rd_fetch && in_bank(fetch_addr, `SPIP_ADDR_STAT_BASE)),
		.mask_wr_i  (wr_strobe && in_bank(addr_q, `SPIP_ADDR_MASK_BASE)),
		.wdata_i    (rx_byte),
		.events_i   (status_event_i),
		.stat_o     (stat_v),
		.mask_o     (mask_v),
		.active_o   (active)
	);

	// Read multiplexer for the fetch address; unmapped reads return zero.
	always @*
	begin
		rdata = `SPIP_ZERO8;
		if (fetch_addr == `SPIP_ADDR_RESET)
			rdata = rst_reg_q;
		else if (fetch_addr == `SPIP_ADDR_SUMMARY)
			// [R23] summary of active sources
			rdata = {{(8-NSTAT){1'b0}}, active};
		else if (fetch_addr == `SPIP_ADDR_LINE_RST)
			rdata = line_rst_q;
		else if (in_bank(fetch_addr, `SPIP_ADDR_STAT_BASE) ||
		         in_bank(fetch_addr, `SPIP_ADDR_MASK_BASE))
			rdata = in_bank(fetch_addr, `SPIP_ADDR_STAT_BASE) ? stat_v : mask_v;
	end

	// Read byte path. The first shift edge after a load keeps bit 7 on the line.
	// The output flop takes the next value, so the line settles a core cycle
	// ahead of the master's sampling edge instead of changing on it.
	wire       tx_step = shift_e && (st_q == ST_DATA) && rd_q;
	wire [7:0] tx_nxt  = rd_fetch ? rdata : ((tx_step && sent_q) ? {tx_q[6:0], 1'b0} : tx_q);

	// ----------------------------------------------------------------
	// Serial engine
	// ----------------------------------------------------------------
	always @(posedge core_clk_i or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			sck_q   <= 1'b0;
			st_q    <= ST_CTL0;
			bit_q   <= 3'h0;
			sh_q    <= `SPIP_ZERO8;
			rd_q    <= 1'b0;
			burst_q <= 1'b0;
			addr_q  <= `SPIP_ZERO8;
			tx_q    <= `SPIP_ZERO8;
			sent_q  <= 1'b0;
		end
		else
		begin
			sck_q <= sck_s;
			// [R9] select release ends access
			if (!port_en)
			begin
				st_q    <= ST_CTL0;
				bit_q   <= 3'h0;
				sh_q    <= `SPIP_ZERO8;
				rd_q    <= 1'b0;
				burst_q <= 1'b0;
				sent_q  <= 1'b0;
			end
			else
			begin
				if (samp_e)
				begin
					// [R4] shift in MSB first
					sh_q  <= rx_byte;
					bit_q <= bit_q + 3'h1;
				end
				if (byte_end)
				begin
					case (st_q)
						ST_CTL0:
						begin
							// [R5] direction and A7
							rd_q        <= rx_byte[`SPIP_CTL0_RW_BIT];
							addr_q[7]   <= rx_byte[`SPIP_CTL0_A7_BIT];
							st_q        <= ST_CTL1;
						end
						ST_CTL1:
						begin
							// [R6] low address and burst
							addr_q[6:0] <= rx_byte[7:1];
							burst_q     <= rx_byte[`SPIP_CTL1_BURST_BIT];
							st_q        <= ST_DATA;
						end
						ST_DATA:
						begin
							// [R7] burst address advance
							// [R8] next write byte
							if (burst_q)
								addr_q <= addr_inc(addr_q);
						end
						default:
							st_q <= ST_CTL0;
					endcase
				end
				// [R13] load read byte
				if (rd_fetch)
					sent_q <= 1'b0;
				else if (tx_step && !sent_q)
					sent_q <= 1'b1;
				tx_q <= tx_nxt;
			end
		end
	end

	// ----------------------------------------------------------------
	// Reset register, line reset and output pins
	// ----------------------------------------------------------------
	reg [31:0] li_cnt_q;
	wire       rst_wr  = wr_strobe && addr_q == `SPIP_ADDR_RESET;
	wire       li_wr   = wr_strobe && addr_q == `SPIP_ADDR_LINE_RST;

	always @(posedge core_clk_i or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			rst_reg_q                <= `SPIP_ZERO8;
			line_rst_q               <= `SPIP_ZERO8;
			soft_clr_q               <= 1'b0;
			li_cnt_q                 <= 32'h0;
			line_interface_reset_o   <= 1'b0;
			output_force_mode_low_o  <= 1'b0;
			output_force_mode_high_o <= 1'b0;
			irq_n_o                  <= 1'b1;
			miso_o                   <= 1'b0;
			miso_oe_o                <= 1'b0;
		end
		else
		begin
			// [R17] rising soft bit clears space, then self-clears
			soft_clr_q <= rst_wr && rx_byte[`SPIP_RST_SOFT_BIT] &&
			              !rst_reg_q[`SPIP_RST_SOFT_BIT];
			if (reg_clear)
			begin
				rst_reg_q   <= `SPIP_ZERO8;
				line_rst_q  <= `SPIP_ZERO8;
			end
			else
			begin
				// [R20] unused bits held at zero
				if (rst_wr)
					rst_reg_q <= rx_byte & `SPIP_RST_USED_MASK;
				if (li_wr)
					line_rst_q <= rx_byte;
			end
			// [R18] line reset on zero-to-one
			if (li_wr && rx_byte[`SPIP_LINE_RST_BIT] && !line_rst_q[`SPIP_LINE_RST_BIT])
				li_cnt_q <= LI_RST_CYC;
			else if (li_cnt_q != 32'h0)
				li_cnt_q <= li_cnt_q - 32'h1;
			line_interface_reset_o <= (li_cnt_q != 32'h0);
			// [R19] force-mode outputs
			output_force_mode_low_o  <= rst_reg_q[`SPIP_RST_FORCE_LO];
			output_force_mode_high_o <= rst_reg_q[`SPIP_RST_FORCE_HI];
			// [R21] masked status drives interrupt
			irq_n_o <= ~(|active);
			// [R24] release data line when idle
			// [R2] drive only for read data
			miso_oe_o <= port_en && rd_q && (st_q == ST_DATA);
			miso_o    <= tx_nxt[7];
		end
	end

endmodule // spip_port

// ---- shared/spip_defines.vh ----
// Constants for the serial register host port: frame layout, register offsets,
// reset-register fields and timing. Definitions only; included by bare name.
`ifndef SPIP_DEFINES_VH
`define SPIP_DEFINES_VH

// Interface select code that enables the serial slave port.
`define SPIP_SEL_SERIAL      2'h2
// Frame layout.
`define SPIP_CTL0_RW_BIT     7
`define SPIP_CTL0_A7_BIT     0
`define SPIP_CTL1_BURST_BIT  0
`define SPIP_BYTE_LAST       3'h7
`define SPIP_BYTE_CTL0       2'h0
`define SPIP_BYTE_CTL1       2'h1
`define SPIP_BYTE_DATA       2'h2
// Register offsets (chosen where none is printed).
`define SPIP_ADDR_RESET      8'h00
`define SPIP_ADDR_SUMMARY    8'h01
`define SPIP_ADDR_STAT_BASE  8'h10
`define SPIP_ADDR_MASK_BASE  8'h18
`define SPIP_ADDR_LINE_RST   8'h20
// Field positions.
`define SPIP_RST_SOFT_BIT    0
`define SPIP_RST_FORCE_LO    4
`define SPIP_RST_FORCE_HI    5
`define SPIP_RST_USED_MASK   8'h31
`define SPIP_LINE_RST_BIT    6
`define SPIP_ZERO8           8'h00
// Line-interface recovery time, in microseconds.
`define SPIP_LI_RECOVER_US   40000
`define SPIP_CLK_MHZ         10

`endif

// ---- src/spip_sync2.v ----
// Two-flop synchroniser for a group of asynchronous level inputs.
// Assumes the destination clock is core_clk_i and reset is already synchronous-released.
`timescale 1ns/1ps

module spip_sync2 #(
	parameter W = 1
) (
	// Clock and reset.
	input  wire         core_clk_i,
	input  wire         rst_n_i,
	// Data.
	input  wire [W-1:0] async_i,
	output reg  [W-1:0] sync_o
);

	reg [W-1:0] meta_q;

	// The first stage feeds only the second stage.
	always @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_q <= {W{1'b0}};
			sync_o <= {W{1'b0}};
		end
		else
		begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end

endmodule // spip_sync2

// ---- src/spip_stat_bank.v ----
// Status and mask registers with the summary of active interrupt sources.
// Assumes event inputs are synchronous to core_clk_i, one bit per status bit.
`timescale 1ns/1ps
`include "spip_defines.vh"

module spip_stat_bank #(
	parameter NREG = 5
) (
	// Clock and reset.
	input  wire            core_clk_i,
	input  wire            rst_n_i,
	input  wire            clear_i,
	// Access.
	input  wire [2:0]      idx_i,
	input  wire            stat_rd_i,
	input  wire            mask_wr_i,
	input  wire [7:0]      wdata_i,
	// Events and results.
	input  wire [8*NREG-1:0] events_i,
	output reg  [7:0]      stat_o,
	output reg  [7:0]      mask_o,
	output wire [NREG-1:0] active_o
);

	reg [7:0] stat_q [0:NREG-1];
	reg [7:0] mask_q [0:NREG-1];
	integer   i;

	// Read views of the selected registers.
	always @*
	begin
		stat_o = `SPIP_ZERO8;
		mask_o = `SPIP_ZERO8;
		for (i = 0; i < NREG; i = i + 1)
			if (idx_i == i[2:0])
			begin
				stat_o = stat_q[i];
				mask_o = mask_q[i];
			end
	end

	// Sticky bits clear on read; a new event in the same cycle wins.
	always @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			for (i = 0; i < NREG; i = i + 1)
			begin
				stat_q[i] <= `SPIP_ZERO8;
				mask_q[i] <= `SPIP_ZERO8;
			end
		end
		else
		begin
			for (i = 0; i < NREG; i = i + 1)
			begin
				if (clear_i)
				begin
					stat_q[i] <= `SPIP_ZERO8;
					mask_q[i] <= `SPIP_ZERO8;
				end
				else
				begin
					stat_q[i] <= ((stat_rd_i && idx_i == i[2:0]) ? `SPIP_ZERO8 : stat_q[i])
						| events_i[8*i +: 8];
					if (mask_wr_i && idx_i == i[2:0])
						mask_q[i] <= wdata_i;
				end
			end
		end
	end

	// Only status bits whose mask bit is set count as active.
	genvar g;
	generate
		for (g = 0; g < NREG; g = g + 1)
		begin : g_act
			assign active_o[g] = |(stat_q[g] & mask_q[g]);
		end
	endgenerate

endmodule // spip_stat_bank

// ---- test/spip_port_assertions.sv ----
// Pin-level checks for the serial host port, bound to spip_port.
// Assumes it sees only that module's ports.
`timescale 1ns/1ps

module spip_port_assertions #(
	parameter NSTAT      = 5,
	parameter LI_RST_CYC = 20
) (
	// Clock, reset and straps.
	input wire               core_clk_i,
	input wire               reset_n_i,
	input wire [1:0]         bus_interface_select_i,
	input wire               cpha_i,
	input wire               cpol_i,
	input wire               hardware_reset_pin_n_i,
	// Serial link.
	input wire               sck_i,
	input wire               mosi_i,
	input wire               cs_n_i,
	input wire               miso_o,
	input wire               miso_oe_o,
	// Block side.
	input wire [8*NSTAT-1:0] status_event_i,
	input wire               irq_n_o,
	input wire               line_interface_reset_o,
	input wire               output_force_mode_low_o,
	input wire               output_force_mode_high_o
);
	// ----
	// Checks
	// ----
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	// Length of the running line reset pulse, so its exact width can be checked.
	logic [31:0] li_cnt_q;
	always @(posedge core_clk_i or negedge reset_n_i)
		if (!reset_n_i)
			li_cnt_q <= 32'h0;
		else
			li_cnt_q <= line_interface_reset_o ? li_cnt_q + 32'h1 : 32'h0;

	chk_miso_released: assert property (cs_n_i [*8] |-> !miso_oe_o)
		else $error("data output driven while deselected");
	chk_port_select: assert property ((bus_interface_select_i != 2'h2) [*8] |-> !miso_oe_o)
		else $error("serial port active with another select code");
	chk_li_width: assert property ($fell(line_interface_reset_o) |-> li_cnt_q == LI_RST_CYC)
		else $error("line reset pulse of wrong length");
	chk_li_bound: assert property (li_cnt_q <= LI_RST_CYC)
		else $error("line reset pulse too long");
	chk_reset_quiet: assert property ($rose(reset_n_i) |-> irq_n_o && !miso_oe_o
		&& !line_interface_reset_o)
		else $error("outputs active at reset release");
	chk_pin_clears: assert property ((!hardware_reset_pin_n_i) [*6] |-> irq_n_o
		&& !output_force_mode_low_o && !output_force_mode_high_o)
		else $error("reset pin did not clear outputs");
	chk_idle_still: assert property ((cs_n_i && hardware_reset_pin_n_i) [*8] |=>
		$stable(output_force_mode_low_o) && $stable(output_force_mode_high_o)
		&& !$rose(line_interface_reset_o))
		else $error("register effect without an access");
	chk_miso_steady: assert property ((miso_oe_o && $stable(sck_i)) [*3] |=> $stable(miso_o))
		else $error("data output moved without a clock edge");
endmodule // spip_port_assertions

// ---- test/spip_master_model.sv ----
// Serial bus master model driving clock, data and select of the port.
// Assumes a 100 ns core clock; a serial half-period is four core cycles.
`timescale 1ns/1ps

module spip_master_model (
	// Clock and straps.
	input  wire  core_clk_i,
	input  wire  cpol_i,
	input  wire  cpha_i,
	// Serial link.
	output logic sck_o,
	output logic mosi_o,
	output logic cs_n_o,
	input  wire  miso_i
);
	logic [7:0] buf_q [0:7];	// Write data in, read data out.

	// Idle link at time zero.
	initial
	begin
		sck_o = 1'b0;
		mosi_o = 1'b0;
		cs_n_o = 1'b1;
	end

	// One bit per clock, edges set by the straps.
	task automatic xbit(input logic b, output logic r);
		if (!cpha_i) mosi_o <= b;
		repeat (4) @(posedge core_clk_i);
		sck_o <= ~cpol_i;
		if (cpha_i) mosi_o <= b; else r = miso_i;
		repeat (4) @(posedge core_clk_i);
		sck_o <= cpol_i;
		if (cpha_i) r = miso_i;
	endtask

	// Two control bytes, then data bits; select release ends it.
	task automatic access(input logic rw, input logic [7:0] a, input logic burst, input int n);
		logic [15:0] ctl;
		logic        r;
		ctl = {rw, 6'h00, a[7], a[6:0], burst};
		sck_o <= cpol_i;
		repeat (4) @(posedge core_clk_i);
		cs_n_o <= 1'b0;
		for (int i = 15; i >= 0; i--) xbit(ctl[i], r);
		for (int i = 0; i < n; i++)
		begin
			xbit(buf_q[i/8][7-i%8], r);
			buf_q[i/8][7-i%8] = r;
		end
		repeat (4) @(posedge core_clk_i);
		cs_n_o <= 1'b1;
		mosi_o <= ~mosi_o;	// A released line must not look like held data.
		repeat (8) @(posedge core_clk_i);
	endtask
endmodule // spip_master_model

// ---- test/test_spip_port.sv ----
// Self-checking bench for the serial host port through the master model.
// Assumes a 10 MHz core clock and a line reset pulse shortened to 20 cycles.
`timescale 1ns/1ps

module test_spip_port;
	// ----
	// Signals
	// ----
	localparam NSTAT      = 5;
	localparam LI_RST_CYC = 20;
	logic               core_clk_i = 1'b0;
	logic               reset_n_i = 1'b0;
	logic [1:0]         bus_interface_select_i = 2'h2;
	logic               cpha_i = 1'b0;
	logic               cpol_i = 1'b0;
	logic               hardware_reset_pin_n_i = 1'b1;
	logic [8*NSTAT-1:0] status_event_i = '0;
	logic               miso_last = 1'b0;
	logic [7:0]         bexp [0:3] = '{8'hA5, 8'h3C, 8'hC3, 8'h5A};
	int                 errors = 0;
	int                 comparisons = 0;
	wire                sck_i, mosi_i, cs_n_i, miso_o, miso_oe_o, miso_w, irq_n_o;
	wire                line_interface_reset_o, output_force_mode_low_o, output_force_mode_high_o;

	// Clock; a released data line shows the inverse of its last bit.
	always #50 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i)
		if (miso_oe_o)
			miso_last <= miso_o;
	assign miso_w = miso_oe_o ? miso_o : ~miso_last;

	spip_port #(.NSTAT(NSTAT), .LI_RST_CYC(LI_RST_CYC)) dut (.core_clk_i, .reset_n_i,
		.bus_interface_select_i, .cpha_i, .cpol_i, .hardware_reset_pin_n_i, .sck_i,
		.mosi_i, .cs_n_i, .miso_o, .miso_oe_o, .status_event_i, .irq_n_o,
		.line_interface_reset_o, .output_force_mode_low_o, .output_force_mode_high_o);
	spip_master_model master (.core_clk_i, .cpol_i, .cpha_i, .sck_o(sck_i), .mosi_o(mosi_i),
		.cs_n_o(cs_n_i), .miso_i(miso_w));

	// ----
	// Tasks
	// ----
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		master.buf_q[0] = d;
		master.access(1'b0, a, 1'b0, 8);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		master.access(1'b1, a, 1'b0, 8);
		check($sformatf("reg %h", a), master.buf_q[0], exp);
	endtask
	task automatic pulse(input int i);
		status_event_i[i] <= 1'b1;
		@(posedge core_clk_i);
		status_event_i[i] <= 1'b0;
		repeat (4) @(posedge core_clk_i);
	endtask
	task automatic conclude();
		$display("comparisons %0d, errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Watchdog, well beyond the few thousand cycles the sequence needs.
	initial
	begin
		#3000000;
		errors++;
		conclude();
	end

	// Main sequence.
	initial
	begin
		repeat (8) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		repeat (8) @(posedge core_clk_i);
		check("irq", {7'h00, irq_n_o}, 8'h01);
		rd(8'h18, 8'h00);
		wr(8'h18, 8'hA5);
		rd(8'h18, 8'hA5);
		for (int i = 1; i < 4; i++) master.buf_q[i-1] = bexp[i];
		master.access(1'b0, 8'h19, 1'b1, 24);
		master.access(1'b1, 8'h18, 1'b1, 32);
		for (int i = 0; i < 4; i++) check("burst", master.buf_q[i], bexp[i]);
		master.buf_q[0] = 8'hFF;
		master.access(1'b0, 8'h19, 1'b0, 4);
		rd(8'h19, 8'h3C);
		master.access(1'b1, 8'h18, 1'b1, 3);
		rd(8'h18, 8'hA5);
		master.buf_q[0] = 8'h00;
		master.buf_q[1] = 8'h30;
		master.access(1'b0, 8'hFF, 1'b1, 16);
		rd(8'h00, 8'h30);
		check("force", {6'h00, output_force_mode_high_o, output_force_mode_low_o}, 8'h03);
		master.access(1'b1, 8'hFF, 1'b1, 16);
		check("wrap", master.buf_q[1], 8'h30);
		wr(8'h00, 8'h01);
		rd(8'h00, 8'h00);
		rd(8'h18, 8'h00);
		check("force", {6'h00, output_force_mode_high_o, output_force_mode_low_o}, 8'h00);
		wr(8'h18, 8'h01);
		pulse(0);
		check("irq", {7'h00, irq_n_o}, 8'h00);
		rd(8'h01, 8'h01);
		rd(8'h10, 8'h01);
		rd(8'h10, 8'h00);
		check("irq", {7'h00, irq_n_o}, 8'h01);
		pulse(8);
		check("irq", {7'h00, irq_n_o}, 8'h01);
		pulse(0);
		master.access(1'b1, 8'h0F, 1'b1, 8);
		rd(8'h10, 8'h00);
		wr(8'h20, 8'h40);
		check("line reset", {7'h00, line_interface_reset_o}, 8'h01);
		repeat (30) @(posedge core_clk_i);
		check("line reset", {7'h00, line_interface_reset_o}, 8'h00);
		wr(8'h18, 8'h77);
		hardware_reset_pin_n_i <= 1'b0;
		repeat (8) @(posedge core_clk_i);
		hardware_reset_pin_n_i <= 1'b1;
		repeat (4) @(posedge core_clk_i);
		rd(8'h18, 8'h00);
		for (int c = 0; c < 4; c++)
			if (c != 2)
			begin
				bus_interface_select_i <= c[1:0];
				wr(8'h18, 8'h0F);
				bus_interface_select_i <= 2'h2;
				rd(8'h18, 8'h00);
			end
		for (int m = 0; m < 4; m++)
		begin
			{cpol_i, cpha_i} <= m[1:0];
			@(posedge core_clk_i);
			wr(8'h19, {6'h30, m[1:0]});
			rd(8'h19, {6'h30, m[1:0]});
		end
		conclude();
	end
endmodule // test_spip_port

bind spip_port spip_port_assertions #(.NSTAT(NSTAT), .LI_RST_CYC(LI_RST_CYC)) chk (.core_clk_i,
	.reset_n_i, .bus_interface_select_i, .cpha_i, .cpol_i, .hardware_reset_pin_n_i, .sck_i,
	.mosi_i, .cs_n_i, .miso_o, .miso_oe_o, .status_event_i, .irq_n_o, .line_interface_reset_o,
	.output_force_mode_low_o, .output_force_mode_high_o);
